// ---- design/bsp_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module bsp_unit (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic ODD_EVEN_SEL,
  input wire logic BIG_ENDIAN_SEL,
  input wire logic PORT_A_CLOCK,
  input wire logic PORT_A_CHIP_SELECT_N,
  input wire logic PORT_A_TRANSFER_QUALIFIER,
  input wire logic PORT_A_WRITE_NOT_READ,
  input wire logic PORT_A_MAILBOX_SEL,
  input wire logic PORT_A_PARITY_GEN_SEL,
  input wire logic [35:0] PORT_A_DATA_IN,
  output logic [35:0] PORT_A_DATA_OUT,
  output logic PORT_A_PARITY_FAIL_N,
  input wire logic PORT_B_CLOCK,
  input wire logic PORT_B_CHIP_SELECT_N,
  input wire logic PORT_B_TRANSFER_QUALIFIER,
  input wire logic PORT_B_WRITE_NOT_READ,
  input wire logic PORT_B_WIDTH_SEL0,
  input wire logic PORT_B_WIDTH_SEL1,
  input wire logic BYTE_ORDER_SEL0,
  input wire logic BYTE_ORDER_SEL1,
  input wire logic PORT_B_PARITY_GEN_SEL,
  input wire logic [35:0] PORT_B_DATA_IN,
  output logic [35:0] PORT_B_DATA_OUT,
  output logic PORT_B_PARITY_FAIL_N,
  input wire logic [35:0] A_TO_B_QUEUE_RDATA,
  output logic A_TO_B_QUEUE_POP,
  output logic A_TO_B_QUEUE_PUSH,
  output logic [35:0] A_TO_B_QUEUE_WDATA,
  input wire logic [35:0] B_TO_A_QUEUE_RDATA,
  output logic B_TO_A_QUEUE_POP,
  output logic B_TO_A_QUEUE_PUSH,
  output logic [35:0] B_TO_A_QUEUE_WDATA,
  input wire logic [35:0] MAIL1_DATA,
  input wire logic [35:0] MAIL2_DATA,
  output logic MAIL1_WRITE,
  output logic MAIL2_WRITE,
  output logic [35:0] MAIL_WDATA
);

  function automatic logic par_err(input logic [8:0] b, input logic odd);
    par_err = (^b) ^ odd;
  endfunction

  function automatic logic [35:0] gen_par(input logic [35:0] d, input logic odd);
    logic [35:0] r;
    r = d;
    for (int i = 0; i < bsp_pkg::BSP_NB; i++)
    begin
      r[i*bsp_pkg::BSP_BW + 8] = (^d[i*bsp_pkg::BSP_BW +: 8]) ^ odd;
    end
    gen_par = r;
  endfunction

  function automatic logic [35:0] swap(input logic [35:0] d, input bsp_pkg::bsp_swap_t s);
    logic [8:0] a, b, c, e;
    {a, b, c, e} = d;
    case (s)
      bsp_pkg::BSP_SW_ABCD: swap = {a, b, c, e};
      bsp_pkg::BSP_SW_DCBA: swap = {e, c, b, a};
      bsp_pkg::BSP_SW_CDAB: swap = {c, e, a, b};
      bsp_pkg::BSP_SW_BADC: swap = {b, a, e, c};
      default: swap = d;
    endcase
  endfunction

  function automatic logic [1:0] last_unit(input bsp_pkg::bsp_size_t s);
    case (s)
      bsp_pkg::BSP_SZ_WORD: last_unit = bsp_pkg::BSP_LAST_WORD;
      bsp_pkg::BSP_SZ_BYTE: last_unit = bsp_pkg::BSP_LAST_BYTE;
      default: last_unit = bsp_pkg::BSP_LAST_LONG;
    endcase
  endfunction

  function automatic logic [3:0] valid_mask(input bsp_pkg::bsp_size_t s, input logic be);
    case (s)
      bsp_pkg::BSP_SZ_WORD: valid_mask = be ? bsp_pkg::BSP_MASK_WORD_BE : bsp_pkg::BSP_MASK_WORD_LE;
      bsp_pkg::BSP_SZ_BYTE: valid_mask = be ? bsp_pkg::BSP_MASK_BYTE_BE : bsp_pkg::BSP_MASK_BYTE_LE;
      default: valid_mask = bsp_pkg::BSP_MASK_ALL;
    endcase
  endfunction

  // source lane of unit k: high end first on a big-endian bus, low end first otherwise
  function automatic logic [1:0] unit_lane(input logic [1:0] k, input logic be);
    unit_lane = be ? bsp_pkg::BSP_LANE_TOP - k : k;
  endfunction

  // every pin passes two flops; data is taken on the synchronised clock's rising edge,
  // so pins must be stable a few system cycles around the port clock edge
  logic [bsp_pkg::BSP_A_PINS-1:0] a_s1_q, a_s2_q;
  logic [bsp_pkg::BSP_B_PINS-1:0] b_s1_q, b_s2_q;
  logic a_clk_prev_q, b_clk_prev_q;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      a_s1_q <= '0;
      a_s2_q <= '0;
      b_s1_q <= '0;
      b_s2_q <= '0;
      a_clk_prev_q <= 1'b0;
      b_clk_prev_q <= 1'b0;
    end
    else
    begin
      a_s1_q <= {PORT_A_CLOCK, PORT_A_CHIP_SELECT_N, PORT_A_TRANSFER_QUALIFIER, PORT_A_WRITE_NOT_READ,
                 PORT_A_MAILBOX_SEL, PORT_A_PARITY_GEN_SEL, ODD_EVEN_SEL, PORT_A_DATA_IN};
      a_s2_q <= a_s1_q;
      b_s1_q <= {PORT_B_CLOCK, PORT_B_CHIP_SELECT_N, PORT_B_TRANSFER_QUALIFIER, PORT_B_WRITE_NOT_READ,
                 PORT_B_WIDTH_SEL1, PORT_B_WIDTH_SEL0, BYTE_ORDER_SEL1, BYTE_ORDER_SEL0,
                 PORT_B_PARITY_GEN_SEL, ODD_EVEN_SEL, BIG_ENDIAN_SEL, PORT_B_DATA_IN};
      b_s2_q <= b_s1_q;
      a_clk_prev_q <= a_s2_q[42];
      b_clk_prev_q <= b_s2_q[46];
    end
  end

  logic a_edge, a_cs_n, a_qual, a_wnr, a_mbx, a_pg, a_odd;
  logic [35:0] a_data;
  logic b_edge, b_cs_n, b_qual, b_wnr, b_pg, b_odd, b_be;
  bsp_pkg::bsp_size_t b_sel;
  bsp_pkg::bsp_swap_t b_sw;
  logic [35:0] b_data;

  assign {a_cs_n, a_qual, a_wnr, a_mbx, a_pg, a_odd, a_data} = a_s2_q[41:0];
  assign {b_cs_n, b_qual, b_wnr} = b_s2_q[45:43];
  assign b_sel = bsp_pkg::bsp_size_t'(b_s2_q[42:41]);
  assign b_sw = bsp_pkg::bsp_swap_t'(b_s2_q[40:39]);
  assign {b_pg, b_odd, b_be, b_data} = b_s2_q[38:0];
  assign a_edge = a_s2_q[42] & ~a_clk_prev_q;
  assign b_edge = b_s2_q[46] & ~b_clk_prev_q;

  logic a_sel_ok, a_rd, a_wr, a_mbx_gen;
  logic b_sel_ok, b_rd, b_wr, b_mail, b_mbx_gen;
  assign a_sel_ok = ~a_cs_n & a_qual;
  assign a_rd = a_sel_ok & ~a_wnr;
  assign a_wr = a_sel_ok & a_wnr;
  assign a_mbx_gen = a_rd & a_mbx & a_pg;
  assign b_sel_ok = ~b_cs_n & b_qual;
  assign b_rd = b_sel_ok & ~b_wnr;
  assign b_wr = b_sel_ok & b_wnr;
  assign b_mail = (b_sel == bsp_pkg::BSP_SZ_MAIL);
  assign b_mbx_gen = b_rd & b_mail & b_pg;

  // one tree per byte per port; parity generation builds its own trees in gen_par
  logic [3:0] a_err, b_err;
  for (genvar i = 0; i < bsp_pkg::BSP_NB; i++)
  begin : g_tree
    assign a_err[i] = par_err(a_data[i*bsp_pkg::BSP_BW +: bsp_pkg::BSP_BW], a_odd);
    assign b_err[i] = par_err(b_data[i*bsp_pkg::BSP_BW +: bsp_pkg::BSP_BW], b_odd);
  end

  // implemented bus size: stored on each edge, used from the next; a mailbox access keeps it
  bsp_pkg::bsp_size_t size_q;
  logic be_q;
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      size_q <= bsp_pkg::BSP_SZ_LONG;
      be_q <= 1'b0;
    end
    else if (b_edge && !b_mail)
    begin
      size_q <= b_sel;
      be_q <= b_be;
    end
  end

  logic [3:0] b_valid;
  assign b_valid = b_mail ? bsp_pkg::BSP_MASK_ALL : valid_mask(size_q, be_q);

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      PORT_A_PARITY_FAIL_N <= 1'b1;
      PORT_B_PARITY_FAIL_N <= 1'b1;
    end
    else
    begin
      PORT_A_PARITY_FAIL_N <= a_mbx_gen | ~(|a_err);
      PORT_B_PARITY_FAIL_N <= b_mbx_gen | ~(|(b_err & b_valid));
    end
  end

  // port A: writes store all nine bits of each byte, reads substitute parity on request
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      A_TO_B_QUEUE_PUSH <= 1'b0;
      A_TO_B_QUEUE_WDATA <= bsp_pkg::BSP_DATA_RST;
      MAIL1_WRITE <= 1'b0;
      B_TO_A_QUEUE_POP <= 1'b0;
      PORT_A_DATA_OUT <= bsp_pkg::BSP_DATA_RST;
    end
    else
    begin
      A_TO_B_QUEUE_PUSH <= a_edge & a_wr & ~a_mbx;
      MAIL1_WRITE <= a_edge & a_wr & a_mbx;
      B_TO_A_QUEUE_POP <= a_edge & a_rd & ~a_mbx;
      if (a_edge && a_wr)
      begin
        A_TO_B_QUEUE_WDATA <= a_data;
      end
      if (a_edge && a_rd)
      begin
        // mailbox is only read here, never rewritten
        if (a_mbx)
        begin
          PORT_A_DATA_OUT <= a_pg ? gen_par(MAIL2_DATA, a_odd) : MAIL2_DATA;
        end
        else
        begin
          PORT_A_DATA_OUT <= a_pg ? gen_par(B_TO_A_QUEUE_RDATA, a_odd) : B_TO_A_QUEUE_RDATA;
        end
      end
    end
  end

  // port-B reads of the first queue
  logic [1:0] rd_cnt_q, rd_k, wr_cnt_q, wr_k;
  bsp_pkg::bsp_size_t rd_size_q, wr_size_q;
  bsp_pkg::bsp_swap_t wr_sw_q, wr_sw;
  logic [35:0] rd_long_q, rd_long, wr_asm_q, wr_asm;
  logic rd_new, wr_new, b_qrd, b_qwr;
  logic [1:0] rd_src, wr_dst;

  assign b_qrd = b_edge & b_rd & ~b_mail;
  assign b_qwr = b_edge & b_wr & ~b_mail;
  // a size change drops the unread rest of the held long word
  assign rd_new = (rd_cnt_q == bsp_pkg::BSP_CNT_RST) || (size_q != rd_size_q);
  assign rd_k = rd_new ? bsp_pkg::BSP_CNT_RST : rd_cnt_q;
  assign rd_src = unit_lane(rd_k, be_q);
  // parity first, swap second, then bus-size sequencing; selects taken only at load
  assign rd_long = rd_new ? swap(b_pg ? gen_par(A_TO_B_QUEUE_RDATA, b_odd) : A_TO_B_QUEUE_RDATA, b_sw)
                          : rd_long_q;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      rd_cnt_q <= bsp_pkg::BSP_CNT_RST;
      rd_size_q <= bsp_pkg::BSP_SZ_LONG;
      rd_long_q <= bsp_pkg::BSP_DATA_RST;
      A_TO_B_QUEUE_POP <= 1'b0;
      PORT_B_DATA_OUT <= bsp_pkg::BSP_DATA_RST;
    end
    else
    begin
      A_TO_B_QUEUE_POP <= b_qrd & rd_new;
      if (b_edge && b_rd && b_mail)
      begin
        PORT_B_DATA_OUT <= b_pg ? gen_par(MAIL1_DATA, b_odd) : MAIL1_DATA;
      end
      else if (b_qrd)
      begin
        rd_long_q <= rd_long;
        rd_size_q <= size_q;
        rd_cnt_q <= (rd_k == last_unit(size_q)) ? bsp_pkg::BSP_CNT_RST : 2'(rd_k + 2'h1);
        // unused lanes keep their last value
        case (size_q)
          bsp_pkg::BSP_SZ_WORD:
          begin
            if (be_q)
              PORT_B_DATA_OUT[35:18] <= rd_src[0] ? rd_long[35:18] : rd_long[17:0];
            else
              PORT_B_DATA_OUT[17:0] <= rd_src[0] ? rd_long[35:18] : rd_long[17:0];
          end
          bsp_pkg::BSP_SZ_BYTE:
          begin
            if (be_q)
              PORT_B_DATA_OUT[35:27] <= rd_long[rd_src*bsp_pkg::BSP_BW +: bsp_pkg::BSP_BW];
            else
              PORT_B_DATA_OUT[8:0] <= rd_long[rd_src*bsp_pkg::BSP_BW +: bsp_pkg::BSP_BW];
          end
          default: PORT_B_DATA_OUT <= rd_long;
        endcase
      end
    end
  end

  // port-B writes to the second queue: assemble first, swap as the long word is stored
  assign wr_new = (wr_cnt_q == bsp_pkg::BSP_CNT_RST) || (size_q != wr_size_q);
  assign wr_k = wr_new ? bsp_pkg::BSP_CNT_RST : wr_cnt_q;
  assign wr_dst = unit_lane(wr_k, be_q);
  assign wr_sw = wr_new ? b_sw : wr_sw_q;

  always_comb
  begin
    wr_asm = wr_asm_q;
    case (size_q)
      bsp_pkg::BSP_SZ_WORD:
      begin
        if (wr_dst[0])
          wr_asm[35:18] = be_q ? b_data[35:18] : b_data[17:0];
        else
          wr_asm[17:0] = be_q ? b_data[35:18] : b_data[17:0];
      end
      bsp_pkg::BSP_SZ_BYTE: wr_asm[wr_dst*bsp_pkg::BSP_BW +: bsp_pkg::BSP_BW] = be_q ? b_data[35:27] : b_data[8:0];
      default: wr_asm = b_data;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      wr_cnt_q <= bsp_pkg::BSP_CNT_RST;
      wr_size_q <= bsp_pkg::BSP_SZ_LONG;
      wr_sw_q <= bsp_pkg::BSP_SW_ABCD;
      wr_asm_q <= bsp_pkg::BSP_DATA_RST;
      B_TO_A_QUEUE_PUSH <= 1'b0;
      B_TO_A_QUEUE_WDATA <= bsp_pkg::BSP_DATA_RST;
      MAIL2_WRITE <= 1'b0;
      MAIL_WDATA <= bsp_pkg::BSP_DATA_RST;
    end
    else
    begin
      B_TO_A_QUEUE_PUSH <= b_qwr && (wr_k == last_unit(size_q));
      MAIL2_WRITE <= b_edge & b_wr & b_mail;
      if (b_edge && b_wr && b_mail)
        MAIL_WDATA <= b_data;
      else if (a_edge && a_wr && a_mbx)
        MAIL_WDATA <= a_data;
      if (b_qwr)
      begin
        wr_asm_q <= wr_asm;
        wr_sw_q <= wr_sw;
        wr_size_q <= size_q;
        wr_cnt_q <= (wr_k == last_unit(size_q)) ? bsp_pkg::BSP_CNT_RST : 2'(wr_k + 2'h1);
        if (wr_k == last_unit(size_q))
          B_TO_A_QUEUE_WDATA <= swap(wr_asm, wr_sw);
      end
    end
  end

  a_fail_flag_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (|a_err && !a_mbx_gen) |=> !PORT_A_PARITY_FAIL_N) else $error("port A parity error not flagged");
  a_flag_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    a_mbx_gen |=> PORT_A_PARITY_FAIL_N) else $error("port A flag not held high on mailbox read");
  b_flag_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    b_mbx_gen |=> PORT_B_PARITY_FAIL_N) else $error("port B flag not held high on mailbox read");
  b_flag_ignore_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (!b_mail && size_q == bsp_pkg::BSP_SZ_BYTE && be_q && !b_err[3]) |=> PORT_B_PARITY_FAIL_N)
    else $error("port B flag reacts to unused byte");
  long_push_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (b_qwr && size_q == bsp_pkg::BSP_SZ_LONG) |=> B_TO_A_QUEUE_PUSH
      && B_TO_A_QUEUE_WDATA == swap($past(b_data), $past(b_sw))) else $error("long write not swapped");
  mail2_write_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (b_edge && b_wr && b_mail) |=> MAIL2_WRITE && MAIL_WDATA == $past(b_data) && !B_TO_A_QUEUE_PUSH)
    else $error("mailbox 2 write misrouted");
  mail1_read_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (b_edge && b_rd && b_mail && !b_pg) |=> PORT_B_DATA_OUT == $past(MAIL1_DATA) && !A_TO_B_QUEUE_POP)
    else $error("mailbox 1 not on port B");
  mail2_gen_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (a_edge && a_mbx_gen) |=> (PORT_A_DATA_OUT[8] == ((^$past(MAIL2_DATA[7:0])) ^ $past(a_odd)))
      && PORT_A_DATA_OUT[7:0] == $past(MAIL2_DATA[7:0])) else $error("generated parity wrong");
  word_pop_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (b_qrd && !rd_new && size_q == bsp_pkg::BSP_SZ_WORD) |=> !A_TO_B_QUEUE_POP)
    else $error("second word popped the queue");

endmodule
`default_nettype wire

// ---- common/bsp_pkg.sv ----
package bsp_pkg;
  localparam int BSP_DW = 36;
  localparam int BSP_BW = 9;
  localparam int BSP_NB = 4;
  localparam int BSP_HW = 18;
  // port-B bus size codes, width_sel1 is the upper bit
  typedef enum logic [1:0] {
    BSP_SZ_LONG = 2'b00,
    BSP_SZ_WORD = 2'b01,
    BSP_SZ_BYTE = 2'b10,
    BSP_SZ_MAIL = 2'b11
  } bsp_size_t;
  // byte orders from B35-B27 down to B8-B0
  typedef enum logic [1:0] {
    BSP_SW_ABCD = 2'b00,
    BSP_SW_DCBA = 2'b01,
    BSP_SW_CDAB = 2'b10,
    BSP_SW_BADC = 2'b11
  } bsp_swap_t;
  localparam logic [1:0] BSP_LAST_LONG = 2'h0;
  localparam logic [1:0] BSP_LAST_WORD = 2'h1;
  localparam logic [1:0] BSP_LAST_BYTE = 2'h3;
  localparam logic [1:0] BSP_CNT_RST = 2'h0;
  localparam logic [35:0] BSP_DATA_RST = 36'h0;
  localparam logic [3:0] BSP_MASK_ALL = 4'hf;
  localparam logic [3:0] BSP_MASK_WORD_BE = 4'hc;
  localparam logic [3:0] BSP_MASK_WORD_LE = 4'h3;
  localparam logic [3:0] BSP_MASK_BYTE_BE = 4'h8;
  localparam logic [3:0] BSP_MASK_BYTE_LE = 4'h2;
  localparam logic [1:0] BSP_LANE_TOP = 2'h3;
  localparam logic [1:0] BSP_LANE_BOT = 2'h0;
  // synchronised pin bundle widths
  localparam int BSP_A_PINS = 43;
  localparam int BSP_B_PINS = 47;
endpackage

// ---- tb/bsp_store.sv ----
`timescale 1ns/1ps
`default_nettype none
module bsp_store (
  input wire logic clk,
  input wire logic rst,
  input wire logic ab_push,
  input wire logic ab_pop,
  input wire logic [35:0] ab_wd,
  output logic [35:0] ab_rd,
  input wire logic ba_push,
  input wire logic ba_pop,
  input wire logic [35:0] ba_wd,
  output logic [35:0] ba_rd,
  input wire logic m1_wr,
  input wire logic m2_wr,
  input wire logic [35:0] m_wd,
  output logic [35:0] m1_q,
  output logic [35:0] m2_q
);
  logic [35:0] ab_mem[$];
  logic [35:0] ba_mem[$];
  logic [35:0] junk_q;
  // empty heads toggle so a stray pop never sees a stale word
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ab_mem.delete();
      ba_mem.delete();
      junk_q <= 36'h5a5a5a5a5;
      ab_rd <= 36'h5a5a5a5a5;
      ba_rd <= 36'h5a5a5a5a5;
      m1_q <= 36'h0;
      m2_q <= 36'h0;
    end
    else
    begin
      junk_q <= ~junk_q;
      if (ab_pop && ab_mem.size() > 0)
        void'(ab_mem.pop_front());
      if (ab_push)
        ab_mem.push_back(ab_wd);
      if (ba_pop && ba_mem.size() > 0)
        void'(ba_mem.pop_front());
      if (ba_push)
        ba_mem.push_back(ba_wd);
      ab_rd <= (ab_mem.size() > 0) ? ab_mem[0] : ~junk_q;
      ba_rd <= (ba_mem.size() > 0) ? ba_mem[0] : ~junk_q;
      if (m1_wr)
        m1_q <= m_wd;
      if (m2_wr)
        m2_q <= m_wd;
    end
  end
endmodule
`default_nettype wire

// ---- tb/test_byte_swap_parity_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_byte_swap_parity_unit;
  logic clk, rst, odd, be, a_clk, a_cs_n, a_q, a_wnr, a_mb, a_gen, a_fail;
  logic b_clk, b_cs_n, b_q, b_wnr, b_s0, b_s1, os0, os1, b_gen, b_fail;
  logic ab_pop, ab_push, ba_pop, ba_push, m1w, m2w;
  logic [35:0] a_din, a_dout, b_din, b_dout, ab_rd, ab_wd, ba_rd, ba_wd, m1, m2, mwd, d, w, g, bad, mk;
  int err_total, total_checks, pops, p0, u;
  logic [1:0] fz [5] = '{2'b00, 2'b01, 2'b01, 2'b10, 2'b10};
  logic fe [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  int ign [5] = '{4, 1, 2, 2, 0};
  int hit [5] = '{0, 2, 0, 3, 1};
  bsp_unit dut (.CLK_SYS(clk), .RST(rst), .ODD_EVEN_SEL(odd), .BIG_ENDIAN_SEL(be),
    .PORT_A_CLOCK(a_clk), .PORT_A_CHIP_SELECT_N(a_cs_n), .PORT_A_TRANSFER_QUALIFIER(a_q),
    .PORT_A_WRITE_NOT_READ(a_wnr), .PORT_A_MAILBOX_SEL(a_mb), .PORT_A_PARITY_GEN_SEL(a_gen),
    .PORT_A_DATA_IN(a_din), .PORT_A_DATA_OUT(a_dout), .PORT_A_PARITY_FAIL_N(a_fail),
    .PORT_B_CLOCK(b_clk), .PORT_B_CHIP_SELECT_N(b_cs_n), .PORT_B_TRANSFER_QUALIFIER(b_q),
    .PORT_B_WRITE_NOT_READ(b_wnr), .PORT_B_WIDTH_SEL0(b_s0), .PORT_B_WIDTH_SEL1(b_s1),
    .BYTE_ORDER_SEL0(os0), .BYTE_ORDER_SEL1(os1), .PORT_B_PARITY_GEN_SEL(b_gen),
    .PORT_B_DATA_IN(b_din), .PORT_B_DATA_OUT(b_dout), .PORT_B_PARITY_FAIL_N(b_fail),
    .A_TO_B_QUEUE_RDATA(ab_rd), .A_TO_B_QUEUE_POP(ab_pop), .A_TO_B_QUEUE_PUSH(ab_push),
    .A_TO_B_QUEUE_WDATA(ab_wd), .B_TO_A_QUEUE_RDATA(ba_rd), .B_TO_A_QUEUE_POP(ba_pop),
    .B_TO_A_QUEUE_PUSH(ba_push), .B_TO_A_QUEUE_WDATA(ba_wd), .MAIL1_DATA(m1), .MAIL2_DATA(m2),
    .MAIL1_WRITE(m1w), .MAIL2_WRITE(m2w), .MAIL_WDATA(mwd));
  bsp_store store (.clk(clk), .rst(rst), .ab_push(ab_push), .ab_pop(ab_pop), .ab_wd(ab_wd),
    .ab_rd(ab_rd), .ba_push(ba_push), .ba_pop(ba_pop), .ba_wd(ba_wd), .ba_rd(ba_rd),
    .m1_wr(m1w), .m2_wr(m2w), .m_wd(mwd), .m1_q(m1), .m2_q(m2));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
    if (ab_pop === 1'b1)
      pops++;
  function automatic logic [35:0] swp(input logic [35:0] x, input logic [1:0] s);
    case (s)
      2'b00: return x;
      2'b01: return {x[8:0], x[17:9], x[26:18], x[35:27]};
      2'b10: return {x[17:9], x[8:0], x[35:27], x[26:18]};
      default: return {x[26:18], x[35:27], x[8:0], x[17:9]};
    endcase
  endfunction
  function automatic logic [35:0] gen(input logic [35:0] x, input logic o);
    logic [35:0] r;
    r = x;
    for (int i = 0; i < 4; i++)
      r[9*i+8] = o ? ~^x[9*i +: 8] : ^x[9*i +: 8];
    return r;
  endfunction
  // k-th bus unit of a long word, right aligned
  function automatic logic [35:0] unit(input logic [35:0] x, input int k);
    return be ? (x << (u * k)) >> (36 - u) : (x >> (u * k)) & mk;
  endfunction
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // pins held well beyond the sync depth on both sides of the port edge
  task automatic pa(input logic wr, input logic mb, input logic gn, input logic [35:0] x);
    @(posedge clk);
    a_cs_n <= 1'b0;
    a_q <= 1'b1;
    a_wnr <= wr;
    a_mb <= mb;
    a_gen <= gn;
    a_din <= x;
    repeat (4) @(posedge clk);
    a_clk <= 1'b1;
    repeat (4) @(posedge clk);
    a_clk <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic pb(input logic q, input logic wr, input logic [1:0] z, input logic [1:0] s, input logic gn,
    input logic [35:0] x);
    @(posedge clk);
    b_cs_n <= 1'b0;
    b_q <= q;
    b_wnr <= wr;
    {b_s1, b_s0} <= z;
    {os1, os0} <= s;
    b_gen <= gn;
    b_din <= x;
    repeat (4) @(posedge clk);
    b_clk <= 1'b1;
    repeat (4) @(posedge clk);
    b_clk <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic fl(input logic [35:0] ad, input logic [35:0] bd, input logic ea, input logic eb);
    @(posedge clk);
    a_din <= ad;
    b_din <= bd;
    repeat (6) @(posedge clk);
    chk("port A fail flag", {35'h0, ea}, {35'h0, a_fail});
    chk("port B fail flag", {35'h0, eb}, {35'h0, b_fail});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    {rst, odd, be} = 3'b110;
    {a_clk, a_cs_n, a_q, a_wnr, a_mb, a_gen} = 6'b010000;
    {b_clk, b_cs_n, b_q, b_wnr, b_s0, b_s1, os0, os1, b_gen} = 9'b010000000;
    a_din = 36'h0;
    b_din = 36'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    for (int s = 0; s < 4; s++)
    begin
      d = 36'h34b18713c ^ 36'(s);
      pa(1'b1, 1'b0, 1'b0, d);
      pb(1'b1, 1'b0, 2'b00, 2'(s), 1'b0, 36'h0);
      chk("long read", swp(d, 2'(s)), b_dout);
      pb(1'b1, 1'b1, 2'b00, 2'(s), 1'b0, d);
      pa(1'b0, 1'b0, 1'b0, 36'h0);
      chk("long write", swp(d, 2'(s)), a_dout);
    end
    $display("test long swap done");
    d = 36'h1f00ff0a5;
    pa(1'b1, 1'b0, 1'b0, d);
    pb(1'b1, 1'b0, 2'b00, 2'b01, 1'b1, 36'h0);
    chk("gen read B", swp(gen(d, 1'b1), 2'b01), b_dout);
    pb(1'b1, 1'b1, 2'b00, 2'b00, 1'b0, d);
    pa(1'b0, 1'b0, 1'b1, 36'h0);
    chk("gen read A", gen(d, 1'b1), a_dout);
    $display("test parity gen done");
    for (int e = 1; e >= 0; e--)
      for (int z = 1; z <= 2; z++)
      begin
        u = (z == 1) ? 18 : 9;
        mk = (36'h1 << u) - 36'h1;
        @(posedge clk);
        be <= e[0];
        pb(1'b0, 1'b0, 2'(z), 2'b00, 1'b0, 36'h0);
        d = 36'h9a5c3b1e7 ^ 36'(z * 16 + e);
        pa(1'b1, 1'b0, 1'b0, d);
        p0 = pops;
        w = swp(d, 2'b01);
        for (int k = 0; k < 36 / u; k++)
        begin
          pb(1'b1, 1'b0, 2'(z), (k == 0) ? 2'b01 : 2'b10, 1'b0, 36'h0);
          chk("narrow read", unit(w, k), be ? b_dout >> (36 - u) : b_dout & mk);
        end
        chk("pops per long word", 36'h1, 36'(pops - p0));
        for (int k = 0; k < 36 / u; k++)
          pb(1'b1, 1'b1, 2'(z), (k == 0) ? 2'b01 : 2'b10, 1'b0, be ? unit(d, k) << (36 - u) : unit(d, k));
        pa(1'b0, 1'b0, 1'b0, 36'h0);
        chk("narrow write", w, a_dout);
      end
    $display("test narrow done");
    g = gen(36'h2d4b6a1c5, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      be <= fe[i];
      pb(1'b0, 1'b0, fz[i], 2'b00, 1'b0, 36'h0);
      fl(g, g ^ (36'h1 << (9 * ign[i])), 1'b1, 1'b1);
      fl(g ^ (36'h1 << (9 * hit[i])), g ^ (36'h1 << (9 * hit[i])), 1'b0, 1'b0);
    end
    $display("test parity check done");
    bad = g ^ 36'h1;
    pb(1'b1, 1'b1, 2'b11, 2'b01, 1'b0, bad);
    chk("mailbox 2 write", bad, m2);
    pa(1'b0, 1'b1, 1'b1, g ^ 36'h200);
    chk("mailbox 2 gen", gen(bad, 1'b1), a_dout);
    chk("port A flag held", 36'h1, {35'h0, a_fail});
    pa(1'b0, 1'b1, 1'b0, g);
    chk("mailbox 2 kept", bad, a_dout);
    pa(1'b1, 1'b1, 1'b0, bad);
    pb(1'b1, 1'b0, 2'b11, 2'b01, 1'b1, g ^ 36'h40000);
    chk("mailbox 1 gen", gen(bad, 1'b1), b_dout);
    chk("port B flag held", 36'h1, {35'h0, b_fail});
    pb(1'b1, 1'b0, 2'b11, 2'b10, 1'b0, g);
    chk("mailbox 1 kept", bad, b_dout);
    $display("test mailbox done");
    @(posedge clk);
    odd <= 1'b0;
    pb(1'b0, 1'b0, 2'b00, 2'b00, 1'b0, 36'h0);
    fl(gen(g, 1'b0), gen(g, 1'b0), 1'b1, 1'b1);
    fl(g, g, 1'b0, 1'b0);
    $display("test even parity done");
    results();
  end
endmodule
`default_nettype wire
